/* rtl/dsthr_pkg.sv */
// package: register map, field layout and threshold decode for dsthr block
package dsthr_pkg;
    localparam int DSTHR_AW = 5;
    localparam int DSTHR_DW = 8;
    localparam logic [DSTHR_AW-1:0] DSTHR_ADDR_PHASE_A = 5'h09;
    localparam logic [DSTHR_AW-1:0] DSTHR_ADDR_PHASE_B = 5'h0A;
    localparam logic [DSTHR_DW-1:0] DSTHR_RESET_VAL = 8'h99;
    localparam logic [3:0] DSTHR_FIELD_RESET = 4'h9;
    localparam logic [DSTHR_DW-1:0] DSTHR_UNMAPPED_READ = 8'h00;
    localparam int DSTHR_CODES = 16;
    localparam int DSTHR_MV_W = 11;

    // threshold in millivolts for each 4-bit code
    localparam logic [DSTHR_MV_W-1:0] DSTHR_MV_TABLE [DSTHR_CODES] = '{
        11'h03C, 11'h082, 11'h0C8, 11'h104, 11'h136, 11'h1C2, 11'h212,
        11'h258, 11'h2A8, 11'h2EE, 11'h3AC, 11'h46A, 11'h514, 11'h5DC,
        11'h6A4, 11'h758};

    // one register: low-side field in bits 7-4, high-side in bits 3-0
    typedef struct packed {
        logic [3:0] low_side;
        logic [3:0] high_side;
    } dsthr_reg_s;

    typedef struct packed {
        logic wr_en;
        logic rd_en;
        logic [DSTHR_AW-1:0] addr;
        logic [DSTHR_DW-1:0] wdata;
    } dsthr_req_s;

    typedef struct packed {
        logic [DSTHR_MV_W-1:0] low_side_mv;
        logic [DSTHR_MV_W-1:0] high_side_mv;
    } dsthr_mv_s;
endpackage : dsthr_pkg

/* rtl/dsthr_decode.sv */
// decoder: one threshold register into two millivolt levels
`timescale 1ns/1ps
module dsthr_decode import dsthr_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register value in, decoded levels out
    input dsthr_reg_s cfg,
    output dsthr_mv_s mv
);
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            mv.low_side_mv <= DSTHR_MV_TABLE[DSTHR_FIELD_RESET];
            mv.high_side_mv <= DSTHR_MV_TABLE[DSTHR_FIELD_RESET];
        end else begin
            mv.low_side_mv <= DSTHR_MV_TABLE[cfg.low_side];
            mv.high_side_mv <= DSTHR_MV_TABLE[cfg.high_side];
        end
    end

    AST_DECODE_LOW: assert property (
        @(posedge core_clk) disable iff (rst)
        mv.low_side_mv == DSTHR_MV_TABLE[$past(cfg.low_side)])
        else $error("low-side threshold decode wrong");

    AST_DECODE_HIGH: assert property (
        @(posedge core_clk) disable iff (rst)
        $changed(cfg.high_side) |=>
            mv.high_side_mv == DSTHR_MV_TABLE[$past(cfg.high_side)])
        else $error("high-side threshold did not follow code");
endmodule : dsthr_decode

/* rtl/dsthr_regs.sv */
// drain-source overcurrent threshold registers for phases a and b
// Functional notes
// - phase a register sits at address 0x09 and resets to 0x99.
// - phase a bits 7-4: writable low-side threshold, default 1001b.
// - phase a bits 3-0: writable high-side threshold, default 1001b.
// - phase b register sits at address 0x0A and resets to 0x99.
// - phase b bits 7-4: writable low-side threshold, default 1001b.
// - phase b bits 3-0: writable high-side threshold, default 1001b.
// - each 4-bit code selects 0.06 V up to 1.88 V in ascending steps.
`timescale 1ns/1ps
module dsthr_regs import dsthr_pkg::*; (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register access from the serial configuration front end
    input dsthr_req_s req,
    output logic [DSTHR_DW-1:0] rdata,
    output logic rvalid,
    // field values to the monitors
    output logic [3:0] low_side_a_threshold,
    output logic [3:0] high_side_a_threshold,
    output logic [3:0] low_side_b_threshold,
    output logic [3:0] high_side_b_threshold,
    // decoded levels in millivolts
    output dsthr_mv_s phase_a_mv,
    output dsthr_mv_s phase_b_mv
);
    dsthr_reg_s phase_a_overcurrent_threshold;
    dsthr_reg_s phase_b_overcurrent_threshold;
    logic hit_a;
    logic hit_b;
    dsthr_reg_s wr_fields;

    // write data split into fields, only for the checks below
    assign wr_fields = req.wdata;
    assign hit_a = (req.addr == DSTHR_ADDR_PHASE_A);
    assign hit_b = (req.addr == DSTHR_ADDR_PHASE_B);

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_a_overcurrent_threshold <= DSTHR_RESET_VAL;
        end else if (req.wr_en && hit_a) begin
            phase_a_overcurrent_threshold <= req.wdata;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            phase_b_overcurrent_threshold <= DSTHR_RESET_VAL;
        end else if (req.wr_en && hit_b) begin
            phase_b_overcurrent_threshold <= req.wdata;
        end
    end

    // read data registered one cycle after the request
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata <= DSTHR_UNMAPPED_READ;
            rvalid <= 1'b0;
        end else begin
            rvalid <= req.rd_en;
            if (!req.rd_en) begin
                rdata <= rdata;
            end else if (hit_a) begin
                rdata <= phase_a_overcurrent_threshold;
            end else if (hit_b) begin
                rdata <= phase_b_overcurrent_threshold;
            end else begin
                rdata <= DSTHR_UNMAPPED_READ;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            low_side_a_threshold <= DSTHR_FIELD_RESET;
            high_side_a_threshold <= DSTHR_FIELD_RESET;
            low_side_b_threshold <= DSTHR_FIELD_RESET;
            high_side_b_threshold <= DSTHR_FIELD_RESET;
        end else begin
            low_side_a_threshold <= phase_a_overcurrent_threshold.low_side;
            high_side_a_threshold <= phase_a_overcurrent_threshold.high_side;
            low_side_b_threshold <= phase_b_overcurrent_threshold.low_side;
            high_side_b_threshold <= phase_b_overcurrent_threshold.high_side;
        end
    end

    dsthr_decode u_dec_a (
        .core_clk(core_clk),
        .rst(rst),
        .cfg(phase_a_overcurrent_threshold),
        .mv(phase_a_mv)
    );

    dsthr_decode u_dec_b (
        .core_clk(core_clk),
        .rst(rst),
        .cfg(phase_b_overcurrent_threshold),
        .mv(phase_b_mv)
    );

    sequence s_write_a;
        req.wr_en && hit_a;
    endsequence

    sequence s_write_b;
        req.wr_en && hit_b;
    endsequence

    sequence s_read_a;
        req.rd_en && hit_a && !req.wr_en;
    endsequence

    sequence s_read_b;
        req.rd_en && hit_b && !req.wr_en;
    endsequence

    sequence s_read_other;
        req.rd_en && !hit_a && !hit_b;
    endsequence

    AST_RESET_A: assert property (
        @(posedge core_clk)
        $fell(rst) |-> phase_a_overcurrent_threshold == DSTHR_RESET_VAL)
        else $error("phase a reset value wrong");

    AST_RESET_B: assert property (
        @(posedge core_clk)
        $fell(rst) |-> phase_b_overcurrent_threshold == DSTHR_RESET_VAL)
        else $error("phase b reset value wrong");

    AST_RESET_FIELDS: assert property (
        @(posedge core_clk)
        $fell(rst) |-> low_side_a_threshold == DSTHR_FIELD_RESET
            && high_side_a_threshold == DSTHR_FIELD_RESET
            && low_side_b_threshold == DSTHR_FIELD_RESET
            && high_side_b_threshold == DSTHR_FIELD_RESET)
        else $error("threshold fields not at default after reset");

    AST_RESET_READ: assert property (
        @(posedge core_clk)
        $fell(rst) |-> !rvalid && rdata == DSTHR_UNMAPPED_READ)
        else $error("read port not idle after reset");

    AST_WR_LOW_A: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_a |=> ##1
            low_side_a_threshold == $past(wr_fields.low_side, 2))
        else $error("phase a low-side field not written");

    AST_WR_HIGH_A: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_a |=> ##1
            high_side_a_threshold == $past(wr_fields.high_side, 2))
        else $error("phase a high-side field not written");

    AST_WR_LOW_B: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_b |=> ##1
            low_side_b_threshold == $past(wr_fields.low_side, 2))
        else $error("phase b low-side field not written");

    AST_WR_HIGH_B: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_b |=> ##1
            high_side_b_threshold == $past(wr_fields.high_side, 2))
        else $error("phase b high-side field not written");

    AST_NO_CROSS: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_a |=> $stable(phase_b_overcurrent_threshold))
        else $error("phase a write disturbed phase b");

    AST_NO_CROSS_B: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_b |=> $stable(phase_a_overcurrent_threshold))
        else $error("phase b write disturbed phase a");

    AST_HOLD_UNMAPPED: assert property (
        @(posedge core_clk) disable iff (rst)
        req.wr_en && !hit_a && !hit_b |=>
            $stable(phase_a_overcurrent_threshold)
            && $stable(phase_b_overcurrent_threshold))
        else $error("write to another address changed a register");

    AST_READBACK_A: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_a ##1 s_read_a |=> rvalid && rdata == $past(req.wdata, 2))
        else $error("phase a readback mismatch");

    AST_READBACK_B: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_b ##1 s_read_b |=> rvalid && rdata == $past(req.wdata, 2))
        else $error("phase b readback mismatch");

    AST_READ_A: assert property (
        @(posedge core_clk) disable iff (rst)
        s_read_a |=> rdata == $past(phase_a_overcurrent_threshold))
        else $error("phase a read returned wrong value");

    AST_READ_B: assert property (
        @(posedge core_clk) disable iff (rst)
        s_read_b |=> rdata == $past(phase_b_overcurrent_threshold))
        else $error("phase b read returned wrong value");

    AST_READ_OTHER: assert property (
        @(posedge core_clk) disable iff (rst)
        s_read_other |=> rvalid && rdata == DSTHR_UNMAPPED_READ)
        else $error("read of another address not zero");

    AST_RVALID_SET: assert property (
        @(posedge core_clk) disable iff (rst)
        req.rd_en |=> rvalid)
        else $error("read strobe not answered");

    AST_RVALID_PULSE: assert property (
        @(posedge core_clk) disable iff (rst)
        !req.rd_en |=> !rvalid)
        else $error("read valid without a read strobe");

    AST_RDATA_HOLD: assert property (
        @(posedge core_clk) disable iff (rst)
        !req.rd_en |=> $stable(rdata))
        else $error("read data changed without a read");

    AST_DECODE_A: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_a |=> ##1
            phase_a_mv.low_side_mv ==
                DSTHR_MV_TABLE[$past(wr_fields.low_side, 2)]
            && phase_a_mv.high_side_mv ==
                DSTHR_MV_TABLE[$past(wr_fields.high_side, 2)])
        else $error("phase a decoded level wrong");

    AST_DECODE_B: assert property (
        @(posedge core_clk) disable iff (rst)
        s_write_b |=> ##1
            phase_b_mv.low_side_mv ==
                DSTHR_MV_TABLE[$past(wr_fields.low_side, 2)]
            && phase_b_mv.high_side_mv ==
                DSTHR_MV_TABLE[$past(wr_fields.high_side, 2)])
        else $error("phase b decoded level wrong");
endmodule : dsthr_regs

/* verif/dsthr_ctrl.sv */
// controller model: single-byte register accesses
`timescale 1ns/1ps
module dsthr_ctrl import dsthr_pkg::*; (
    // clock
    input wire logic core_clk,
    // request to the registers
    output dsthr_req_s req
);
    initial req = '0;
    // one-cycle strobe, launched and released at falling edges
    task automatic acc(input logic w, input logic [DSTHR_AW-1:0] a,
        input logic [DSTHR_DW-1:0] d);
        @(negedge core_clk);
        req <= '{w, !w, a, d};
        @(negedge core_clk);
        req <= '0;
    endtask : acc
    // write then read of one register on consecutive strobes
    task automatic wr_rd(input logic [DSTHR_AW-1:0] a,
        input logic [DSTHR_DW-1:0] d);
        @(negedge core_clk);
        req <= '{1'b1, 1'b0, a, d};
        @(negedge core_clk);
        req <= '{1'b0, 1'b1, a, 8'h00};
        @(negedge core_clk);
        req <= '0;
    endtask : wr_rd
endmodule : dsthr_ctrl

/* verif/test_dsthr_regs.sv */
// testbench for the drain-source threshold registers
`timescale 1ns/1ps
module test_dsthr_regs import dsthr_pkg::*;;
    logic core_clk = 0;
    logic rst = 1;
    dsthr_req_s req;
    logic [7:0] rdata;
    logic rvalid;
    logic [3:0] la, ha, lb, hb;
    dsthr_mv_s amv, bmv;
    int err_total = 0;
    int tests_run = 0;
    int mv_tab [16] = '{60, 130, 200, 260, 310, 450, 530, 600, 680,
        750, 940, 1130, 1300, 1500, 1700, 1880};
    always #10 core_clk = ~core_clk;
    dsthr_ctrl PM (.core_clk(core_clk), .req(req));
    dsthr_regs DUT (.core_clk(core_clk), .rst(rst), .req(req),
        .rdata(rdata), .rvalid(rvalid), .low_side_a_threshold(la),
        .high_side_a_threshold(ha), .low_side_b_threshold(lb),
        .high_side_b_threshold(hb), .phase_a_mv(amv), .phase_b_mv(bmv));
    task automatic chk(input string n, input logic [21:0] e, g);
        tests_run++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", n, e, g);
        end
    endtask : chk
    task automatic rd(input logic [4:0] a, input logic [7:0] e);
        PM.acc(0, a, 8'h00);
        chk("rvalid", 1, rvalid);
        chk("rdata", e, rdata);
        @(negedge core_clk);
        chk("rvalid low", 0, rvalid);
    endtask : rd
    task automatic chk_f(input logic [7:0] a, b);
        @(negedge core_clk);
        chk("phase a fields", a, {la, ha});
        chk("phase b fields", b, {lb, hb});
        chk("phase a mv", {11'(mv_tab[a[7:4]]), 11'(mv_tab[a[3:0]])},
            amv);
        chk("phase b mv", {11'(mv_tab[b[7:4]]), 11'(mv_tab[b[3:0]])},
            bmv);
    endtask : chk_f
    task automatic t_reset;
        chk_f(8'h99, 8'h99);
        rd(DSTHR_ADDR_PHASE_A, 8'h99);
        rd(DSTHR_ADDR_PHASE_B, 8'h99);
    endtask : t_reset
    task automatic t_write;
        PM.acc(1, DSTHR_ADDR_PHASE_A, 8'h3C);
        PM.acc(1, DSTHR_ADDR_PHASE_B, 8'hC3);
        chk_f(8'h3C, 8'hC3);
        rd(DSTHR_ADDR_PHASE_A, 8'h3C);
        rd(DSTHR_ADDR_PHASE_B, 8'hC3);
    endtask : t_write
    task automatic t_decode;
        logic [3:0] c;
        for (int i = 0; i < 16; i++) begin
            c = 4'(i);
            PM.acc(1, DSTHR_ADDR_PHASE_A, {c, ~c});
            PM.acc(1, DSTHR_ADDR_PHASE_B, {~c, c});
            chk_f({c, ~c}, {~c, c});
        end
    endtask : t_decode
    task automatic t_unmapped;
        PM.acc(1, 5'h0B, 8'h00);
        PM.acc(1, 5'h08, 8'h00);
        rd(5'h0B, DSTHR_UNMAPPED_READ);
        rd(5'h08, DSTHR_UNMAPPED_READ);
        chk_f(8'hF0, 8'h0F);
    endtask : t_unmapped
    task automatic t_back_to_back;
        PM.wr_rd(DSTHR_ADDR_PHASE_A, 8'h5A);
        chk("rvalid", 1, rvalid);
        chk("rdata", 8'h5A, rdata);
        PM.wr_rd(DSTHR_ADDR_PHASE_B, 8'hA5);
        chk("rvalid", 1, rvalid);
        chk("rdata", 8'hA5, rdata);
        chk_f(8'h5A, 8'hA5);
        chk("rdata hold", 8'hA5, rdata);
    endtask : t_back_to_back
    task automatic end_of_test;
        $display("checks %0d errors %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : end_of_test
    initial begin
        #50us;
        err_total++;
        end_of_test();
    end
    initial begin
        repeat (4) @(negedge core_clk);
        rst = 0;
        t_reset();
        t_write();
        t_decode();
        t_unmapped();
        t_back_to_back();
        end_of_test();
    end
endmodule : test_dsthr_regs
